// ---- bench/edr_mem_model.sv ----
// Static memory on the far side of the data lines, plus pin resolution.
// Assumes the device's data and control pins as the block presents them.
`timescale 1ns/100ps
`default_nettype none

module edr_mem_model
  import edr_pkg::*;
(
  input wire logic             clk_i,
  input wire edr_ctl_t         ctl_i,
  input wire logic             ctl_oe_i,
  input wire logic [DATA_W-1:0] dev_d_i,
  input wire logic [DATA_W-1:0] dev_oe_i,
  input wire logic [PF_W-1:0]  pullup_i,
  output logic     [DATA_W-1:0] bus_o
);
  logic [DATA_W-1:0] last;
  logic [DATA_W-1:0] mem_d;

  assign mem_d = ctl_i.addr[15:0] ^ 16'h5AC3;
  always_ff @(posedge clk_i) last <= bus_o;

  // A released line rises through an enabled pull-up, else shows the inverse of its last level.
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      if (dev_oe_i[i]) bus_o[i] = dev_d_i[i];
      else if (ctl_oe_i && !ctl_i.rd_n) bus_o[i] = mem_d[i];
      else if (i >= PF_BASE && pullup_i[i-PF_BASE]) bus_o[i] = 1'b1;
      else bus_o[i] = ~last[i];
    end
  end
endmodule : edr_mem_model

`default_nettype wire

// ---- bench/edr_read_pins_assertions.sv ----
// Concurrent checks on the pins of the external memory read block.
// Assumes it is bound into edr_read_pins and shares its clock and reset.
`timescale 1ns/100ps
`default_nettype none

module edr_read_pins_checks
  import edr_pkg::*;
#(
  parameter int unsigned RD_LOW_CYCLES = RD_LOW_CYC
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             ack_o,
  input wire logic [DATA_W-1:0] ext_data_lines_oe_o,
  input wire edr_ctl_t         ctl_o,
  input wire logic             ctl_oe_o,
  input wire logic [PF_W-1:0]  port_f_pullup_o,
  input wire logic             rd_pullup_o
);
  int unsigned low_cnt;

  // Counts the cycles of the current low strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i || ctl_o.rd_n) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack lasted two cycles");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_strobe_len: assert property ($rose(ctl_o.rd_n) |-> low_cnt == RD_LOW_CYCLES)
    else $error("strobe low length wrong");
  a_rd_inputs: assert property (!ctl_o.rd_n |-> ext_data_lines_oe_o[PF_BASE-1:0] == '0)
    else $error("data driven while strobe low");
  a_rd_qualify: assert property (!ctl_o.rd_n |-> ctl_oe_o && $onehot(~{ctl_o.program_select_n,
    ctl_o.data_select_n, ctl_o.chip_select_n}))
    else $error("strobe without one select");
  a_addr_hold: assert property (!ctl_o.rd_n |=> ctl_o.addr == $past(ctl_o.addr))
    else $error("address moved under strobe");
  a_strobe_setup: assert property ($fell(ctl_o.rd_n) |-> $past(ctl_oe_o)
    && ctl_o.addr == $past(ctl_o.addr))
    else $error("address not set before strobe");
  a_idle_float: assert property (!ctl_oe_o |-> ctl_o.rd_n
    && ext_data_lines_oe_o[PF_BASE-1:0] == '0)
    else $error("bus driven while released");
  a_reset_pins: assert property ($fell(rst_i) |-> port_f_pullup_o == 9'h1FF && rd_pullup_o
    && ext_data_lines_oe_o == '0 && !ctl_oe_o)
    else $error("pins wrong after reset");
endmodule : edr_read_pins_checks

bind edr_read_pins edr_read_pins_checks #(.RD_LOW_CYCLES(RD_LOW_CYCLES)) edr_read_pins_checks_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .ext_data_lines_oe_o(ext_data_lines_oe_o), .ctl_o(ctl_o), .ctl_oe_o(ctl_oe_o),
  .port_f_pullup_o(port_f_pullup_o), .rd_pullup_o(rd_pullup_o));

`default_nettype wire

// ---- bench/edr_read_pins_test.sv ----
// Self-checking bench for the external memory read block.
// Assumes the memory model in edr_mem_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none

module edr_read_pins_test;
  import edr_pkg::*;
  localparam int RDC = 3;
  logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, stb = 1'b0, cyc = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat;
  logic [DATA_W-1:0] bus, d_o, d_oe;
  logic [PF_W-1:0] pu;
  logic rpu, ctl_oe;
  logic [2:0] seen_sel;
  logic [23:0] seen_adr;
  edr_ctl_t ctl;
  int n_errors = 0, checks_done = 0, cycles = 0;

  edr_read_pins #(.RD_LOW_CYCLES(RDC)) edr_read_pins_i (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel), .stb_i(stb),
    .cyc_i(cyc), .ack_o(ack), .ext_data_lines_i(bus), .ext_data_lines_o(d_o),
    .ext_data_lines_oe_o(d_oe), .ctl_o(ctl), .ctl_oe_o(ctl_oe), .port_f_pullup_o(pu),
    .rd_pullup_o(rpu));
  edr_mem_model edr_mem_model_i (.clk_i(clk_i), .ctl_i(ctl), .ctl_oe_i(ctl_oe),
    .dev_d_i(d_o), .dev_oe_i(d_oe), .pullup_i(pu), .bus_o(bus));

  always #12.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (ctl.rd_n === 1'b0) begin
      seen_sel <= {ctl.program_select_n, ctl.data_select_n, ctl.chip_select_n};
      seen_adr <= ctl.addr;
    end
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s %h/%h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; adr <= a; we <= w; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb

  task automatic t_reset();
    logic [31:0] q;
    logic [7:0] ra [7] = '{REG_BUS_CTRL, REG_PF_FUNC, REG_PF_DIR, REG_PF_OUT,
                           REG_PF_PULLUP, REG_SYS_PUD, 8'h3C};
    logic [31:0] rv [7] = '{32'h0, 32'h1FF, 32'h0, 32'h0, 32'h1FF, 32'h0, 32'h0};
    check(32'({pu, rpu, d_oe, ctl_oe}), 32'({9'h1FF, 1'b1, 16'h0, 1'b0}), "reset pins");
    wb(8'h3C, 1'b1, 32'hFFFF_FFFF, q);
    for (int i = 0; i < 7; i++) begin
      wb(ra[i], 1'b0, 32'h0, q);
      check(q, rv[i], "reset value");
    end
  endtask : t_reset

  task automatic t_read(input logic drv);
    logic [31:0] q, st;
    logic [23:0] a;
    for (int s = 0; s < 3; s++) begin
      a = 24'h9E5A00 + 24'(s * 24'h010203) + 24'(drv);
      wb(REG_RD_START, 1'b1, {6'h0, 2'(s), a}, q);
      wb(REG_RD_START, 1'b1, 32'h0100_0000, q);
      st = 32'h0;
      for (int n = 0; n < 20 && st[STAT_DONE_BIT] !== 1'b1; n++) wb(REG_RD_STATUS, 1'b0, 0, st);
      check(32'(st[15:0]), 32'(a[15:0] ^ 16'h5AC3), "read data");
      check(32'({seen_sel, seen_adr}), 32'({~(3'b100 >> s), a}), "select address");
      wb(REG_RD_START, 1'b0, 32'h0, q);
      check(q, {6'h0, 2'(s), a}, "start while busy");
      wb(REG_RD_STATUS, 1'b1, 32'h0002_0000, q);
    end
  endtask : t_read

  task automatic t_idle();
    logic [31:0] q;
    wb(REG_BUS_CTRL, 1'b1, 32'h1, q);
    repeat (2) @(posedge clk_i);
    check(32'({ctl_oe, d_oe[PF_BASE-1:0]}), 32'h0FF, "idle drive");
  endtask : t_idle

  task automatic t_gpio();
    logic [31:0] q;
    wb(REG_PF_FUNC, 1'b1, 32'h0, q);
    wb(REG_PF_DIR, 1'b1, 32'h1FF, q);
    wb(REG_PF_OUT, 1'b1, 32'h0A5, q);
    wb(REG_PF_IN, 1'b0, 32'h0, q);
    check(q, 32'h0A5, "pin level");
    check(32'({d_oe[15:7], d_o[15:7]}), 32'({9'h1FF, 9'h0A5}), "port out");
    wb(REG_PF_DIR, 1'b1, 32'h0, q);
    @(posedge clk_i);
    check(32'(d_oe[15:7]), 32'h0, "port in");
    wb(REG_PF_IN, 1'b0, 32'h0, q);
    check(q, 32'h1FF, "pulled-up inputs");
    wb(REG_PF_PULLUP, 1'b1, 32'h1FE, q);
    wb(REG_SYS_PUD, 1'b1, 32'h1, q);
    @(posedge clk_i);
    check(32'({pu, rpu}), 32'({9'h1FE, 1'b0}), "pull-ups");
  endtask : t_gpio

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_read(1'b0);
    t_idle();
    t_read(1'b1);
    t_gpio();
    complete_run();
  end
endmodule : edr_read_pins_test

`default_nettype wire

// ---- design/edr_pkg.sv ----
// Package for the external memory upper data and read strobe block.
// Assumes a 40 MHz system clock and a classic Wishbone register bus.
package edr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned RD_LOW_NS     = 50;
  localparam int unsigned RD_LOW_CYC    = (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned DATA_W   = 16;
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned PF_W     = 9;
  localparam int unsigned PF_BASE  = 7;

  localparam logic [7:0] REG_BUS_CTRL  = 8'h00;
  localparam logic [7:0] REG_PF_FUNC   = 8'h04;
  localparam logic [7:0] REG_PF_DIR    = 8'h08;
  localparam logic [7:0] REG_PF_OUT    = 8'h0C;
  localparam logic [7:0] REG_PF_PULLUP = 8'h10;
  localparam logic [7:0] REG_PF_IN     = 8'h14;
  localparam logic [7:0] REG_SYS_PUD   = 8'h18;
  localparam logic [7:0] REG_RD_START  = 8'h1C;
  localparam logic [7:0] REG_RD_STATUS = 8'h20;

  localparam int unsigned BUS_DRIVE_BIT  = 0;
  localparam int unsigned RD_PUD_BIT     = 0;
  localparam int unsigned START_SPACE_LO = 24;
  localparam int unsigned STAT_BUSY_BIT  = 16;
  localparam int unsigned STAT_DONE_BIT  = 17;

  localparam logic          BUS_DRIVE_RST = 1'b0;
  localparam logic [PF_W-1:0] PF_FUNC_RST   = 9'h1FF;
  localparam logic [PF_W-1:0] PF_DIR_RST    = 9'h000;
  localparam logic [PF_W-1:0] PF_OUT_RST    = 9'h000;
  localparam logic [PF_W-1:0] PF_PULLUP_RST = 9'h1FF;
  localparam logic          RD_PUD_RST    = 1'b0;

  typedef enum logic [1:0] {
    EDR_SPACE_PROG = 2'b00,
    EDR_SPACE_DATA = 2'b01,
    EDR_SPACE_CHIP = 2'b10
  } edr_space_t;

  typedef enum logic [1:0] {
    EDR_ST_IDLE   = 2'b00,
    EDR_ST_SETUP  = 2'b01,
    EDR_ST_STROBE = 2'b10,
    EDR_ST_HOLD   = 2'b11
  } edr_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd_n;
    logic              program_select_n;
    logic              data_select_n;
    logic              chip_select_n;
  } edr_ctl_t;

endpackage : edr_pkg

// ---- design/edr_read_pins.sv ----
// External memory read port with upper data lines shared with port F pins.
// Assumes a classic Wishbone master and pins sampled synchronously to clk_i.
//
// Behaviour
// - Upper data lines carry their part of words.
// - Idle bus tri-stated unless bus drive set.
// - Each port F pin is input or output.
// - Shared pins select data bus after reset.
// - Cleared port F pull-up bit turns pull-up off.
// - Read strobe low for whole read cycle; block drives it low only in the strobe state, high in setup and hold.
// - Strobe low makes data lines inputs, except port F pins set as outputs.
// - Read data captured as strobe rises.
// - Low strobe qualifies address and select lines.
// - Set disable bit turns strobe pull-up off.
`timescale 1ns/100ps
`default_nettype none

module edr_read_pins
  import edr_pkg::*;
#(
  parameter int unsigned RD_LOW_CYCLES = RD_LOW_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  input  wire logic                we_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic                stb_i,
  input  wire logic                cyc_i,
  output logic                     ack_o,
  input  wire logic [DATA_W-1:0]   ext_data_lines_i,
  output logic      [DATA_W-1:0]   ext_data_lines_o,
  output logic      [DATA_W-1:0]   ext_data_lines_oe_o,
  output edr_ctl_t                 ctl_o,
  output logic                     ctl_oe_o,
  output logic      [PF_W-1:0]     port_f_pullup_o,
  output logic                     rd_pullup_o
);

  logic              bus_drive_select;
  logic [PF_W-1:0]   port_f_func;
  logic [PF_W-1:0]   port_f_dir;
  logic [PF_W-1:0]   port_f_out;
  logic [PF_W-1:0]   port_f_pullup_enable;
  logic              rd_pullup_disable;
  logic [ADDR_W-1:0] rd_addr;
  edr_space_t        rd_space;
  logic [DATA_W-1:0] rd_data;
  logic              rd_done;
  edr_state_t        state;
  edr_state_t        next_state;
  logic [7:0]        strobe_cnt;
  logic              bus_hit;
  logic              wr_hit;
  logic              start_req;
  logic              space_ok;
  logic              done_clr;
  logic [31:0]       wmask;
  logic [31:0]       next_dat;
  logic              next_busy;
  logic              next_ctl_oe;
  edr_ctl_t          next_ctl;
  logic [DATA_W-1:0] next_data_oe;
  logic [DATA_W-1:0] next_data_out;

  localparam logic [7:0] STROBE_LAST = 8'(RD_LOW_CYCLES - 1);

  // A new request is taken once; ack rises one cycle later and then drops.
  assign bus_hit = cyc_i & stb_i & ~ack_o;
  assign wr_hit  = bus_hit & we_i;
  assign wmask   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // A start naming no memory space is refused, so every strobe carries one select.
  assign space_ok  = (dat_i[START_SPACE_LO+1:START_SPACE_LO] <= EDR_SPACE_CHIP);
  assign start_req = wr_hit && (adr_i == REG_RD_START) && (state == EDR_ST_IDLE) && space_ok;
  assign done_clr  = wr_hit && (adr_i == REG_RD_STATUS) && sel_i[2] && dat_i[STAT_DONE_BIT];

  // Bus handshake.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_hit;
    end
  end

  // Read data path, unmapped addresses read as zero.
  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (adr_i)
      REG_BUS_CTRL:  next_dat[BUS_DRIVE_BIT] = bus_drive_select;
      REG_PF_FUNC:   next_dat[PF_W-1:0] = port_f_func;
      REG_PF_DIR:    next_dat[PF_W-1:0] = port_f_dir;
      REG_PF_OUT:    next_dat[PF_W-1:0] = port_f_out;
      REG_PF_PULLUP: next_dat[PF_W-1:0] = port_f_pullup_enable;
      REG_PF_IN:     next_dat[PF_W-1:0] = ext_data_lines_i[DATA_W-1:PF_BASE];
      REG_SYS_PUD:   next_dat[RD_PUD_BIT] = rd_pullup_disable;
      REG_RD_START:  next_dat = {6'h00, rd_space, rd_addr};
      REG_RD_STATUS: next_dat = {14'h0000, rd_done, state != EDR_ST_IDLE, rd_data};
      default:       next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_hit && !we_i) begin
      dat_o <= next_dat;
    end
  end

  // Bus control register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_drive_select <= BUS_DRIVE_RST;
    end else if (wr_hit && adr_i == REG_BUS_CTRL && sel_i[0]) begin
      bus_drive_select <= dat_i[BUS_DRIVE_BIT];
    end
  end

  // Port F function select; data bus function out of reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_f_func <= PF_FUNC_RST;
    end else if (wr_hit && adr_i == REG_PF_FUNC) begin
      port_f_func <= (port_f_func & ~wmask[PF_W-1:0]) | (dat_i[PF_W-1:0] & wmask[PF_W-1:0]);
    end
  end

  // Port F direction, one bit per pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_f_dir <= PF_DIR_RST;
    end else if (wr_hit && adr_i == REG_PF_DIR) begin
      port_f_dir <= (port_f_dir & ~wmask[PF_W-1:0]) | (dat_i[PF_W-1:0] & wmask[PF_W-1:0]);
    end
  end

  // Port F output data.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_f_out <= PF_OUT_RST;
    end else if (wr_hit && adr_i == REG_PF_OUT) begin
      port_f_out <= (port_f_out & ~wmask[PF_W-1:0]) | (dat_i[PF_W-1:0] & wmask[PF_W-1:0]);
    end
  end

  // Port F pull-up enables; bit n belongs to pin n.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_f_pullup_enable <= PF_PULLUP_RST;
    end else if (wr_hit && adr_i == REG_PF_PULLUP) begin
      port_f_pullup_enable <= (port_f_pullup_enable & ~wmask[PF_W-1:0])
                              | (dat_i[PF_W-1:0] & wmask[PF_W-1:0]);
    end
  end

  // System pull-up disable for the read strobe pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pullup_disable <= RD_PUD_RST;
    end else if (wr_hit && adr_i == REG_SYS_PUD && sel_i[0]) begin
      rd_pullup_disable <= dat_i[RD_PUD_BIT];
    end
  end

  // Port F pull-up pins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_f_pullup_o <= PF_PULLUP_RST;
    end else begin
      port_f_pullup_o <= port_f_pullup_enable;
    end
  end

  // Read strobe pull-up pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pullup_o <= ~RD_PUD_RST;
    end else begin
      rd_pullup_o <= ~rd_pullup_disable;
    end
  end

  // Read request address, latched when a read is started.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_addr <= '0;
    end else if (start_req) begin
      rd_addr <= dat_i[ADDR_W-1:0];
    end
  end

  // Read request space, latched when a read is started; only legal codes get here.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_space <= EDR_SPACE_PROG;
    end else if (start_req) begin
      rd_space <= edr_space_t'(dat_i[START_SPACE_LO+1:START_SPACE_LO]);
    end
  end

  // Read cycle sequencer.
  always_comb begin
    next_state = state;
    unique case (state)
      EDR_ST_IDLE: begin
        if (start_req) begin
          next_state = EDR_ST_SETUP;
        end
      end
      EDR_ST_SETUP: begin
        next_state = EDR_ST_STROBE;
      end
      EDR_ST_STROBE: begin
        if (strobe_cnt == STROBE_LAST) begin
          next_state = EDR_ST_HOLD;
        end
      end
      EDR_ST_HOLD: begin
        next_state = EDR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= EDR_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Strobe width counter.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_cnt <= 8'h00;
    end else if (state == EDR_ST_STROBE) begin
      strobe_cnt <= strobe_cnt + 8'h01;
    end else begin
      strobe_cnt <= 8'h00;
    end
  end

  // Captured data and done flag; a new capture wins over a clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data <= '0;
    end else if (state == EDR_ST_STROBE && next_state == EDR_ST_HOLD) begin
      rd_data <= ext_data_lines_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_done <= 1'b0;
    end else if (state == EDR_ST_STROBE && next_state == EDR_ST_HOLD) begin
      rd_done <= 1'b1;
    end else if (done_clr || start_req) begin
      rd_done <= 1'b0;
    end
  end

  // Control pins decoded from the next state so the pins come from flops.
  always_comb begin
    next_busy                 = (next_state != EDR_ST_IDLE);
    next_ctl.addr             = next_busy ? (start_req ? dat_i[ADDR_W-1:0] : rd_addr) : '0;
    next_ctl.rd_n             = (next_state != EDR_ST_STROBE);
    next_ctl.program_select_n = 1'b1;
    next_ctl.data_select_n    = 1'b1;
    next_ctl.chip_select_n    = 1'b1;
    if (next_state == EDR_ST_STROBE) begin
      next_ctl.program_select_n = (rd_space != EDR_SPACE_PROG);
      next_ctl.data_select_n    = (rd_space != EDR_SPACE_DATA);
      next_ctl.chip_select_n    = (rd_space != EDR_SPACE_CHIP);
    end
    next_ctl_oe = next_busy | bus_drive_select;
  end

  // Memory control pins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_o <= '{addr: '0, rd_n: 1'b1, program_select_n: 1'b1,
                 data_select_n: 1'b1, chip_select_n: 1'b1};
    end else begin
      ctl_o <= next_ctl;
    end
  end

  // Control pin enable; released while idle unless bus drive is set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_oe_o <= 1'b0;
    end else begin
      ctl_oe_o <= next_ctl_oe;
    end
  end

  // Per-line data pin control; upper lines may be port F pins instead.
  // Bus lines let go in the setup cycle already, so memory and device never fight.
  for (genvar i = 0; i < DATA_W; i++) begin : g_line
    if (i >= PF_BASE) begin : g_shared
      always_comb begin
        if (!port_f_func[i-PF_BASE]) begin
          next_data_oe[i]  = port_f_dir[i-PF_BASE];
          next_data_out[i] = port_f_out[i-PF_BASE];
        end else begin
          next_data_oe[i]  = !next_busy && bus_drive_select;
          next_data_out[i] = 1'b0;
        end
      end
    end else begin : g_bus_only
      always_comb begin
        next_data_oe[i]  = !next_busy && bus_drive_select;
        next_data_out[i] = 1'b0;
      end
    end
  end

  // Data pin enables.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_data_lines_oe_o <= '0;
    end else begin
      ext_data_lines_oe_o <= next_data_oe;
    end
  end

  // Data pin drive values.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_data_lines_o <= '0;
    end else begin
      ext_data_lines_o <= next_data_out;
    end
  end

endmodule : edr_read_pins

`default_nettype wire
